// [core/flash_cmd_map.vh]
// Purpose: opcodes, frame figures and timing constants of the erase/suspend sequencer
// Assumes: 10 MHz mclk_in; times kept in their own unit, cycles derived in the module
// Notes:   definitions only
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// opcodes
`define OP_CHIP_ERASE_A     8'h60
`define OP_CHIP_ERASE_B     8'hc7
`define OP_SUSPEND          8'hb0
`define OP_RESUME           8'hd0
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_PROGRAM          8'h02
`define OP_PROGRAM_DUAL     8'ha2
`define OP_BLOCK_ERASE_4K   8'h20
`define OP_BLOCK_ERASE_32K  8'h52
`define OP_BLOCK_ERASE_64K  8'hd8

// frame figures
`define BITS_PER_BYTE       3'd7
`define ADDR_BYTES_DONE     3'd4
`define PROG_BYTES_DONE     3'd5
`define BYTE_CNT_MAX        3'd5

// address field holding the 64KB sector number
`define SECTOR_MSB          23
`define SECTOR_LSB          16

// timing
`define CLK_PERIOD_NS       100
`define SUSPEND_LATENCY_NS  20000

`endif

// [core/pin_sync3.v]
// Purpose: three-stage synchroniser for pins arriving from outside the mclk domain
// Assumes: pins change slowly compared with mclk_in
// Notes:   the output only moves once stages two and three agree
`timescale 1ns/1ps
`include "flash_cmd_map.vh"

module pin_sync3 #(
	parameter WIDTH = 3
) (
	// clock and reset
	input  wire             mclk_in,
	input  wire             resetn_in,
	// pins
	input  wire [WIDTH-1:0] pins_in,
	input  wire [WIDTH-1:0] reset_value_in,
	output wire [WIDTH-1:0] pins_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg ff1;
			reg ff2;
			reg ff3;
			reg stable;
			// load each pin's idle level so no false edge follows reset
			always @(posedge mclk_in) begin
				if (!resetn_in) begin
					ff1    <= reset_value_in[i];
					ff2    <= reset_value_in[i];
					ff3    <= reset_value_in[i];
					stable <= reset_value_in[i];
				end else begin
					ff1 <= pins_in[i];
					ff2 <= ff1;
					ff3 <= ff2;
					if (ff2 == ff3) begin
						stable <= ff3;
					end
				end
			end
			assign pins_out[i] = stable;
		end
	endgenerate

endmodule

// [core/chip_erase_and_suspend_control.v]
// Purpose: whole-array erase and program/erase suspend sequencing of a serial flash
// Assumes: SPI mode 0/3, opcode MSB first, bits taken on rising sck while cs_n is low
// Notes:   array data paths live elsewhere; this block times operations and gates commands
// How it works
// RULE1: erase refused unless write latch set
// RULE2: opcodes 60h and C7h both erase
// RULE3: trailing bytes ignored, erase at cs_n rise
// RULE4: erase self-timed by internal counter
// RULE5: partial or misaligned frame performs nothing
// RULE6: protected or locked sector blocks erase
// RULE7: rejected erase clears write latch; a chip erase refused while busy keeps it
// RULE8: busy while erasing, latch cleared before end
// RULE9: failed bytes raise program/erase error flag
// RULE10: host polls status rather than waiting
// RULE11: suspend ignores write latch state
// RULE12: suspend B0h acts within suspend latency
// RULE13: suspend sets matching flag, reports ready
// RULE14: partial suspend frame suspends nothing
// RULE15: reads in suspended sector flagged undefined
// RULE16: program into erase-suspended sector aborts
// RULE17: erase into program-suspended sector aborts
// RULE18: program in other sector during erase suspend
// RULE19: reset during suspend abandons suspended operation
// RULE20: disallowed opcodes ignored, flags untouched
// RULE21: program suspend allows reads, resume, reset
// RULE22: erase suspend also allows program, suspend, latch
// RULE23: pointless suspend leaves flags unchanged
`timescale 1ns/1ps
`include "flash_cmd_map.vh"

module chip_erase_and_suspend_control #(
	parameter CHIP_ERASE_TIME_US  = 2000,
	parameter BLOCK_ERASE_TIME_US = 1000,
	parameter PROGRAM_TIME_US     = 500,
	parameter [7:0]   RESET_OPCODE   = 8'he0,
	parameter [255:0] READ_SAFE_OPS  = 256'h0
) (
	// clock and reset
	input  wire        mclk_in,
	input  wire        resetn_in,
	// serial pins
	input  wire        cs_n_in,
	input  wire        sck_in,
	input  wire        si_in,
	// protection state of the array
	input  wire        any_sector_protected_in,
	input  wire        any_sector_locked_in,
	input  wire        sector_protected_in,
	output wire [7:0]  chk_sector_out,
	// array verify results at completion
	input  wire        erase_fail_in,
	input  wire        program_fail_in,
	// read engine address
	input  wire [23:0] read_addr_in,
	output reg         read_undefined_out,
	// command pass-through to the rest of the device
	output reg         cmd_start_out,
	output reg  [7:0]  cmd_opcode_out,
	// array activity
	output reg         array_erase_out,
	output reg         array_chip_out,
	output reg         array_program_out,
	output reg         erase_abandon_out,
	output reg         program_abandon_out,
	// status flags
	output reg         write_latch_flag_out,
	output reg         ready_busy_flag_out,
	output reg         program_erase_error_flag_out,
	output reg         program_suspended_flag_out,
	output reg         erase_suspended_flag_out
);

	localparam integer CHIP_RAW  = (CHIP_ERASE_TIME_US * 1000) / `CLK_PERIOD_NS;
	localparam integer BLOCK_RAW = (BLOCK_ERASE_TIME_US * 1000) / `CLK_PERIOD_NS;
	localparam integer PROG_RAW  = (PROGRAM_TIME_US * 1000) / `CLK_PERIOD_NS;
	localparam integer SUSP_RAW  = `SUSPEND_LATENCY_NS / `CLK_PERIOD_NS;
	localparam [31:0]  CHIP_CYC  = (CHIP_RAW < 1) ? 32'd1 : CHIP_RAW;
	localparam [31:0]  BLOCK_CYC = (BLOCK_RAW < 1) ? 32'd1 : BLOCK_RAW;
	localparam [31:0]  PROG_CYC  = (PROG_RAW < 1) ? 32'd1 : PROG_RAW;
	localparam [31:0]  SUSP_CYC  = (SUSP_RAW < 1) ? 32'd1 : SUSP_RAW;
	localparam [0:0]   SUSP_IDLE = 1'b0;
	localparam [0:0]   SUSP_WAIT = 1'b1;

	// synchronised pins; sck idles low, cs_n and si high
	wire        cs_n_s;
	wire        sck_s;
	wire        si_s;

	pin_sync3 #(
		.WIDTH(3)
	) u_sync (
		.mclk_in        (mclk_in),
		.resetn_in      (resetn_in),
		.pins_in        ({cs_n_in, sck_in, si_in}),
		.reset_value_in (3'h5),
		.pins_out       ({cs_n_s, sck_s, si_s})
	);

	reg         cs_n_d;
	reg         sck_d;
	reg  [2:0]  bit_cnt;
	reg  [2:0]  byte_cnt;
	reg  [7:0]  shift;
	reg  [7:0]  opcode;
	reg  [23:0] addr;

	// engine state
	reg         write_latch_flag;
	reg         program_erase_error_flag;
	reg         erase_active;
	reg         erase_susp;
	reg         erase_chip;
	reg  [7:0]  erase_sector;
	reg  [31:0] erase_cnt;
	reg         prog_active;
	reg         prog_susp;
	reg  [7:0]  prog_sector;
	reg  [31:0] prog_cnt;
	reg         susp_state;
	reg         susp_prog;
	reg  [31:0] susp_cnt;
	reg         abandon_e;
	reg         abandon_p;

	wire        sck_rise   = ~sck_d & sck_s & ~cs_n_s;
	wire        frame_beg  = cs_n_d & ~cs_n_s;
	wire        frame_end  = ~cs_n_d & cs_n_s;
	wire [7:0]  next_shift = {shift[6:0], si_s};
	wire        aligned    = (bit_cnt == 3'd0) && (byte_cnt != 3'd0); // [RULE5] [RULE14]
	wire [7:0]  cmd_sector = addr[`SECTOR_MSB:`SECTOR_LSB];
	wire        erase_run  = erase_active & ~erase_susp;
	wire        prog_run   = prog_active & ~prog_susp;
	wire        busy       = erase_run | prog_run;
	wire        is_chip    = (opcode == `OP_CHIP_ERASE_A) ||
	                         (opcode == `OP_CHIP_ERASE_B); // [RULE2]
	wire        is_block   = (opcode == `OP_BLOCK_ERASE_4K) ||
	                         (opcode == `OP_BLOCK_ERASE_32K) ||
	                         (opcode == `OP_BLOCK_ERASE_64K);
	wire        is_prog    = (opcode == `OP_PROGRAM) || (opcode == `OP_PROGRAM_DUAL);

	assign chk_sector_out = cmd_sector;

	// which opcodes may run in the present suspend condition
	function allowed;
		input [7:0] op;
		input       ps;
		input       es;
		begin
			if (!ps && !es) begin
				allowed = 1'b1;
			end else if (READ_SAFE_OPS[op] || op == `OP_RESUME || op == RESET_OPCODE) begin
				allowed = 1'b1; // [RULE21]
			end else if (es && !ps) begin
				allowed = (op == `OP_PROGRAM) || (op == `OP_PROGRAM_DUAL) ||
				          (op == `OP_SUSPEND) || (op == `OP_WRITE_ENABLE) ||
				          (op == `OP_WRITE_DISABLE); // [RULE22]
			end else begin
				allowed = 1'b0;
			end
		end
	endfunction

	wire cmd_ok = allowed(opcode, prog_susp, erase_susp);

	// frame capture
	always @(posedge mclk_in) begin
		if (!resetn_in) begin
			cs_n_d         <= 1'b1;
			sck_d          <= 1'b0;
			bit_cnt        <= 3'd0;
			byte_cnt       <= 3'd0;
			shift          <= 8'h00;
			opcode         <= 8'h00;
			addr           <= 24'h000000;
			cmd_start_out  <= 1'b0;
			cmd_opcode_out <= 8'h00;
		end else begin
			cs_n_d        <= cs_n_s;
			sck_d         <= sck_s;
			cmd_start_out <= 1'b0;
			if (frame_beg) begin
				bit_cnt  <= 3'd0;
				byte_cnt <= 3'd0;
			end else if (sck_rise) begin
				shift   <= next_shift;
				bit_cnt <= bit_cnt + 3'd1;
				if (bit_cnt == `BITS_PER_BYTE) begin
					if (byte_cnt != `BYTE_CNT_MAX) begin
						byte_cnt <= byte_cnt + 3'd1;
					end
					case (byte_cnt)
						3'd0: begin
							opcode         <= next_shift;
							cmd_opcode_out <= next_shift;
							// blocked opcodes never reach the status writers
							cmd_start_out  <= allowed(next_shift, prog_susp, erase_susp); // [RULE20]
						end
						3'd1: addr[23:16] <= next_shift;
						3'd2: addr[15:8]  <= next_shift;
						3'd3: addr[7:0]   <= next_shift;
						default: addr     <= addr; // [RULE3]
					endcase
				end
			end
		end
	end

	// command execution and self-timed operations
	always @(posedge mclk_in) begin
		if (!resetn_in) begin
			write_latch_flag          <= 1'b0;
			program_erase_error_flag          <= 1'b0;
			erase_active <= 1'b0;
			erase_susp   <= 1'b0;
			erase_chip   <= 1'b0;
			erase_sector <= 8'h00;
			erase_cnt    <= 32'h0;
			prog_active  <= 1'b0;
			prog_susp    <= 1'b0;
			prog_sector  <= 8'h00;
			prog_cnt     <= 32'h0;
			susp_state   <= SUSP_IDLE;
			susp_prog    <= 1'b0;
			susp_cnt     <= 32'h0;
			abandon_e    <= 1'b0;
			abandon_p    <= 1'b0;
		end else begin
			abandon_e <= 1'b0;
			abandon_p <= 1'b0;
			// countdowns freeze while their operation is suspended
			if (erase_run) begin
				if (erase_cnt == 32'h1) begin
					erase_active <= 1'b0;
					program_erase_error_flag          <= erase_fail_in; // [RULE9]
				end
				erase_cnt <= erase_cnt - 32'h1; // [RULE4]
			end
			if (prog_run) begin
				if (prog_cnt == 32'h1) begin
					prog_active <= 1'b0;
					program_erase_error_flag         <= program_fail_in;
				end
				prog_cnt <= prog_cnt - 32'h1;
			end
			case (susp_state)
				SUSP_IDLE: begin
					susp_cnt <= 32'h0;
				end
				SUSP_WAIT: begin
					if (susp_cnt == 32'h1) begin
						susp_state <= SUSP_IDLE;
						// an operation that finished inside the latency is not marked suspended
						if (susp_prog) begin
							prog_susp <= prog_run && (prog_cnt != 32'h1); // [RULE13]
						end else begin
							erase_susp <= erase_run && (erase_cnt != 32'h1); // [RULE13]
						end
					end
					susp_cnt <= susp_cnt - 32'h1; // [RULE12]
				end
				default: susp_state <= SUSP_IDLE;
			endcase
			if (frame_end && byte_cnt != 3'd0 && cmd_ok) begin
				if (!aligned) begin
					// opcode known but frame broken: erases and programs lose the latch
					if (is_chip || is_block || is_prog) begin
						write_latch_flag <= 1'b0; // [RULE7]
					end
				end else if (opcode == `OP_WRITE_ENABLE) begin
					write_latch_flag <= 1'b1;
				end else if (opcode == `OP_WRITE_DISABLE) begin
					write_latch_flag <= 1'b0;
				end else if (is_chip) begin
					if (busy || erase_active || prog_active) begin
						write_latch_flag <= write_latch_flag;
					end else if (!write_latch_flag) begin
						write_latch_flag <= 1'b0; // [RULE1]
					end else if (any_sector_protected_in || any_sector_locked_in) begin
						write_latch_flag <= 1'b0; // [RULE6] [RULE7]
					end else begin
						write_latch_flag          <= 1'b0; // [RULE8]
						program_erase_error_flag          <= 1'b0;
						erase_active <= 1'b1;
						erase_chip   <= 1'b1;
						erase_cnt    <= CHIP_CYC; // [RULE4]
					end
				end else if (is_block) begin
					if (byte_cnt < `ADDR_BYTES_DONE || !write_latch_flag) begin
						write_latch_flag <= 1'b0;
					end else if (prog_susp && cmd_sector == prog_sector) begin
						write_latch_flag <= 1'b0; // [RULE17]
					end else if (busy || erase_active || prog_active || sector_protected_in) begin
						write_latch_flag <= 1'b0;
					end else begin
						write_latch_flag          <= 1'b0;
						program_erase_error_flag          <= 1'b0;
						erase_active <= 1'b1;
						erase_chip   <= 1'b0;
						erase_sector <= cmd_sector;
						erase_cnt    <= BLOCK_CYC;
					end
				end else if (is_prog) begin
					if (byte_cnt < `PROG_BYTES_DONE || !write_latch_flag) begin
						write_latch_flag <= 1'b0;
					end else if (erase_susp && (erase_chip || cmd_sector == erase_sector)) begin
						write_latch_flag <= 1'b0; // [RULE16]
					end else if (busy || prog_active || sector_protected_in) begin
						write_latch_flag <= 1'b0;
					end else begin
						write_latch_flag         <= 1'b0; // [RULE18]
						program_erase_error_flag         <= 1'b0;
						prog_active <= 1'b1;
						prog_sector <= cmd_sector;
						prog_cnt    <= PROG_CYC;
					end
				end else if (opcode == `OP_SUSPEND) begin
					// write latch not consulted here
					if (susp_state == SUSP_IDLE && prog_run) begin
						susp_state <= SUSP_WAIT; // [RULE11] [RULE12]
						susp_prog  <= 1'b1;
						susp_cnt   <= SUSP_CYC;
					end else if (susp_state == SUSP_IDLE && erase_run) begin
						susp_state <= SUSP_WAIT; // [RULE11] [RULE12]
						susp_prog  <= 1'b0;
						susp_cnt   <= SUSP_CYC;
					end else begin
						susp_state <= susp_state; // [RULE23]
					end
				end else if (opcode == `OP_RESUME) begin
					// program resumes first when both are suspended
					if (prog_susp) begin
						prog_susp <= 1'b0;
					end else if (erase_susp) begin
						erase_susp <= 1'b0;
					end
				end else if (opcode == RESET_OPCODE) begin
					// array contents of the abandoned region are left to the array
					if (erase_susp) begin
						erase_active <= 1'b0; // [RULE19]
						erase_susp   <= 1'b0;
						abandon_e    <= 1'b1;
					end
					if (prog_susp) begin
						prog_active <= 1'b0; // [RULE19]
						prog_susp   <= 1'b0;
						abandon_p   <= 1'b1;
					end
				end
			end
		end
	end

	// registered status and array view
	always @(posedge mclk_in) begin
		if (!resetn_in) begin
			write_latch_flag_out         <= 1'b0;
			ready_busy_flag_out          <= 1'b0;
			program_erase_error_flag_out <= 1'b0;
			program_suspended_flag_out   <= 1'b0;
			erase_suspended_flag_out     <= 1'b0;
			array_erase_out              <= 1'b0;
			array_chip_out               <= 1'b0;
			array_program_out            <= 1'b0;
			erase_abandon_out            <= 1'b0;
			program_abandon_out          <= 1'b0;
			read_undefined_out           <= 1'b0;
		end else begin
			write_latch_flag_out         <= write_latch_flag;
			// busy holds through the suspend latency, ready once the flag is set
			ready_busy_flag_out          <= busy; // [RULE8] [RULE13]
			program_erase_error_flag_out <= program_erase_error_flag;
			program_suspended_flag_out   <= prog_susp;
			erase_suspended_flag_out     <= erase_susp;
			array_erase_out              <= erase_run;
			array_chip_out               <= erase_run & erase_chip;
			array_program_out            <= prog_run;
			erase_abandon_out            <= abandon_e;
			program_abandon_out          <= abandon_p;
			read_undefined_out           <=
				(prog_susp && read_addr_in[`SECTOR_MSB:`SECTOR_LSB] == prog_sector) ||
				(erase_susp && (erase_chip ||
				 read_addr_in[`SECTOR_MSB:`SECTOR_LSB] == erase_sector)); // [RULE15]
		end
	end

endmodule

// [verif/spi_host_model.sv]
// Purpose: host side of the serial link, sends framed commands bit by bit
// Assumes: called just after a falling mclk edge; sck period of 8 mclk
// Notes:   sck rests low outside frames; si is inverted on release, never left at the last bit
`timescale 1ns/1ps
module spi_host_model (
	// clock
	input  wire  mclk_in,
	// serial pins
	output logic cs_n_out,
	output logic sck_out,
	output logic si_out
);
	initial begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
	end
	// left-aligned data, msb first; n below 8 or off a byte boundary makes a broken frame
	task automatic xfer(input logic [47:0] d, input int n);
		cs_n_out = 1'b0;
		for (int i = 0; i < n; i++) begin
			si_out = d[47-i];
			repeat (4) @(negedge mclk_in);
			sck_out = 1'b1;
			repeat (4) @(negedge mclk_in);
			sck_out = 1'b0;
		end
		repeat (4) @(negedge mclk_in);
		cs_n_out = 1'b1;
		si_out = ~si_out;
	endtask
endmodule

// [verif/chip_erase_and_suspend_control_props.sv]
// Purpose: port-level checks of the erase and suspend sequencer
// Assumes: single mclk domain, synchronous active-low reset
// Notes:   the run counter allows one suspend latency on top of the erase time
`timescale 1ns/1ps
module ces_props #(
	parameter CHIP_ERASE_TIME_US = 2000
) (
	input wire       mclk_in,
	input wire       resetn_in,
	input wire       any_sector_protected_in,
	input wire       any_sector_locked_in,
	input wire       cmd_start_out,
	input wire [7:0] cmd_opcode_out,
	input wire       array_erase_out,
	input wire       array_chip_out,
	input wire       program_abandon_out,
	input wire       write_latch_flag_out,
	input wire       ready_busy_flag_out,
	input wire       program_suspended_flag_out,
	input wire       erase_suspended_flag_out
);
	localparam int CHIP_LIM = CHIP_ERASE_TIME_US * 10 + 210;
	logic [15:0] run_cnt;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	always @(posedge mclk_in)
		if (!resetn_in || (!array_chip_out && !erase_suspended_flag_out))
			run_cnt <= 16'h0000;
		else if (array_chip_out)
			run_cnt <= run_cnt + 16'h0001;
	// a resume also raises array_chip_out, so only count starts not preceded by a suspend
	sequence s_fresh_start;
		$rose(array_chip_out) && !$past(erase_suspended_flag_out)
			&& !$past(erase_suspended_flag_out, 2);
	endsequence
	sequence s_susp_req;
		cmd_start_out && cmd_opcode_out == 8'hb0 && array_erase_out;
	endsequence
	sequence s_susp_done;
		##[1:400] erase_suspended_flag_out;
	endsequence
	a_erase_needs_latch: assert property (s_fresh_start |-> $past(write_latch_flag_out))
		else $error("chip erase started without write latch");
	a_latch_cleared: assert property (s_fresh_start |-> !write_latch_flag_out)
		else $error("write latch still set after erase start");
	a_protect_blocks: assert property (
		(any_sector_protected_in || any_sector_locked_in) && !ready_busy_flag_out
		&& !erase_suspended_flag_out |=> !$rose(array_chip_out))
		else $error("chip erase started with a protected sector");
	a_busy_erasing: assert property (array_chip_out |-> ready_busy_flag_out)
		else $error("busy low while chip erase runs");
	a_erase_time_bound: assert property (run_cnt <= CHIP_LIM)
		else $error("chip erase ran past its time");
	a_susp_ready: assert property ($rose(erase_suspended_flag_out)
		|| $rose(program_suspended_flag_out) |=> !ready_busy_flag_out)
		else $error("not ready after suspend");
	a_susp_latency: assert property (s_susp_req |-> s_susp_done)
		else $error("erase suspend too late");
	a_abandon_cause: assert property (program_abandon_out |-> $past(program_suspended_flag_out))
		else $error("program abandoned while not suspended");
	a_ps_no_wren: assert property ($rose(write_latch_flag_out)
		|-> !$past(program_suspended_flag_out))
		else $error("write latch set during program suspend");
endmodule
bind chip_erase_and_suspend_control ces_props #(.CHIP_ERASE_TIME_US(CHIP_ERASE_TIME_US)) i_props (.*);

// [verif/tb_chip_erase_and_suspend_control.sv]
// Purpose: command-level tests of whole-array erase and suspend
// Assumes: shortened op times of 100 us so suspend lands mid-operation
// Notes:   flags = {write latch, busy, erase suspended}
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module tb_chip_erase_and_suspend_control;
	logic        mclk_in = 0, resetn_in = 0, cs_n_in, sck_in, si_in;
	logic        any_sector_protected_in = 0, any_sector_locked_in = 0, sector_protected_in = 0;
	logic        erase_fail_in = 0, program_fail_in = 0;
	logic [23:0] read_addr_in = 24'h000000;
	logic [7:0]  chk_sector_out, cmd_opcode_out;
	logic        read_undefined_out, cmd_start_out, array_erase_out, array_chip_out;
	logic        array_program_out, erase_abandon_out, program_abandon_out, write_latch_flag_out;
	logic        ready_busy_flag_out, program_erase_error_flag_out;
	logic        program_suspended_flag_out, erase_suspended_flag_out;
	int          fail_count = 0, cmp_count = 0;
	int          st_cnt = 0, p_ab = 0, e_ab = 0, st_mark = 0;
	wire [2:0]   flags = {write_latch_flag_out, ready_busy_flag_out, erase_suspended_flag_out};
	initial forever #50 mclk_in = ~mclk_in;
	// one-cycle pulses counted mid-cycle, away from the edge that launches them
	always @(negedge mclk_in) begin
		st_cnt += cmd_start_out;
		p_ab += program_abandon_out;
		e_ab += erase_abandon_out;
	end
	spi_host_model i_host (.mclk_in(mclk_in), .cs_n_out(cs_n_in), .sck_out(sck_in), .si_out(si_in));
	chip_erase_and_suspend_control #(.CHIP_ERASE_TIME_US(100), .BLOCK_ERASE_TIME_US(100),
		.PROGRAM_TIME_US(100), .READ_SAFE_OPS(256'h1 << 224)) i_dut (.*);
	task automatic cmd(input logic [47:0] d, input int n);
		i_host.xfer(d, n);
		repeat (8) @(negedge mclk_in);
	endtask
	task automatic op8(input logic [7:0] o);
		cmd({o, 40'h0}, 8);
	endtask
	// host polls busy instead of sitting out the worst-case time
	task automatic poll(input int lim);
		int k;
		k = 0;
		while (ready_busy_flag_out !== 1'b0 && k < lim) begin
			@(negedge mclk_in);
			k++;
		end
		`CHK(k < lim, 1'b1)
		@(negedge mclk_in);
	endtask
	task close_out;
		$display("mismatches %0d of %0d compares", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_in);
		fail_count++;
		close_out;
	end
	initial begin
		repeat (6) @(negedge mclk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		op8(`OP_CHIP_ERASE_A);
		`CHK(flags, 3'b000)
		op8(`OP_WRITE_ENABLE);
		cmd({`OP_CHIP_ERASE_A, 40'h0}, 9);
		`CHK(flags, 3'b000)
		op8(`OP_WRITE_ENABLE);
		cmd({`OP_CHIP_ERASE_B, 40'h0}, 5);
		`CHK(flags, 3'b100)
		any_sector_protected_in = 1'b1;
		op8(`OP_CHIP_ERASE_B);
		`CHK(flags, 3'b000)
		any_sector_protected_in = 1'b0;
		any_sector_locked_in = 1'b1;
		op8(`OP_WRITE_ENABLE);
		op8(`OP_CHIP_ERASE_A);
		`CHK(flags, 3'b000)
		any_sector_locked_in = 1'b0;
		for (int i = 0; i < 2; i++) begin
			erase_fail_in = (i == 0);
			op8(`OP_WRITE_ENABLE);
			cmd({i ? `OP_CHIP_ERASE_B : `OP_CHIP_ERASE_A, 8'h5a, 32'h0}, 16);
			`CHK(flags, 3'b010)
			poll(1010);
			`CHK(program_erase_error_flag_out, erase_fail_in)
		end
		op8(`OP_WRITE_ENABLE);
		op8(`OP_CHIP_ERASE_A);
		cmd({`OP_SUSPEND, 40'h0}, 4);
		repeat (220) @(negedge mclk_in);
		`CHK(flags, 3'b010)
		cmd({`OP_SUSPEND, 8'hff, 32'h0}, 16);
		poll(210);
		`CHK(flags, 3'b001)
		`CHK(read_undefined_out, 1'b1)
		op8(`OP_WRITE_ENABLE);
		`CHK(flags, 3'b101)
		st_mark = st_cnt;
		op8(`OP_CHIP_ERASE_B);
		`CHK(st_cnt == st_mark, 1'b1)
		op8(`OP_SUSPEND);
		`CHK(st_cnt == st_mark + 1, 1'b1)
		repeat (210) @(negedge mclk_in);
		`CHK(flags, 3'b101)
		op8(`OP_RESUME);
		`CHK(flags, 3'b110)
		poll(1010);
		op8(`OP_SUSPEND);
		repeat (210) @(negedge mclk_in);
		`CHK({flags[1:0], program_suspended_flag_out}, 3'b000)
		op8(`OP_WRITE_ENABLE);
		cmd({`OP_PROGRAM, 24'h030000, 8'ha5, 8'h00}, 40);
		`CHK({flags[1:0], array_program_out}, 3'b101)
		`CHK(chk_sector_out, 8'h03)
		op8(`OP_SUSPEND);
		poll(210);
		`CHK({flags[1:0], program_suspended_flag_out}, 3'b001)
		read_addr_in = 24'h03fff0;
		repeat (2) @(negedge mclk_in);
		`CHK(read_undefined_out, 1'b1)
		read_addr_in = 24'h040000;
		repeat (2) @(negedge mclk_in);
		`CHK(read_undefined_out, 1'b0)
		op8(`OP_WRITE_ENABLE);
		`CHK(write_latch_flag_out, 1'b0)
		op8(8'he0);
		`CHK({flags[1:0], program_suspended_flag_out, p_ab == 1}, 4'b0001)
		op8(`OP_WRITE_ENABLE);
		cmd({`OP_BLOCK_ERASE_64K, 24'h050000, 16'h0}, 32);
		`CHK({flags, array_erase_out}, 4'b0101)
		op8(`OP_SUSPEND);
		`CHK(cmd_opcode_out, `OP_SUSPEND)
		poll(210);
		op8(`OP_WRITE_ENABLE);
		cmd({`OP_PROGRAM, 24'h05ff00, 8'h11, 8'h00}, 40);
		`CHK({flags, array_program_out}, 4'b0010)
		op8(`OP_WRITE_ENABLE);
		cmd({`OP_PROGRAM, 24'h070000, 8'h22, 8'h00}, 40);
		`CHK({flags, array_program_out}, 4'b0111)
		op8(`OP_SUSPEND);
		poll(210);
		`CHK({flags, program_suspended_flag_out}, 4'b0011)
		read_addr_in = 24'h05ffff;
		repeat (2) @(negedge mclk_in);
		`CHK(read_undefined_out, 1'b1)
		op8(8'he0);
		`CHK({flags, program_suspended_flag_out, e_ab == 1, p_ab == 2}, 6'b000011)
		close_out;
	end
endmodule
